// [rtl/dsc_dma_channel.sv]
// dma channel: stop, completion, pause, abort and flag logic with axi4-lite registers
// Summary of operation
// R1: go clears itself on message completion, per sizes and both reload-stop bits.
// R2: reload-stop bits 00: go never clears by itself.
// R3: bits 01 or 11: go clears when destination or source counter reloads; code clears go only on reload of a counter whose own stop bit is set.
// R4: bits 10: go clears on source reload; software sets go for next batch.
// R5: software clearing go halts transfer and keeps configuration intact.
// R6: pause between read and write keeps byte in buffer, unwritten.
// R7: software or hardware start resumes exactly where transfer paused.
// R8: abort source selected by register, effective only while abort enable set.
// R9: enabled abort clears go, start-request enable and abort-request enable.
// R10: abort leaves pointers, counters and buffered byte unchanged.
// R11: clearing enable hard-stops channel back to default operating state.
// R12: source/destination count flags set when respective counter reloads.
// R13: abort flag set on abort trigger while abort enable set.
// R14: overrun flag set on start trigger before previous transaction finished.
// R15: enabled start trigger sets go by hardware.
// R16: software re-sets start and abort enables to rearm after abort.
// R17: control main: enable 7, start-req 6, go 5, abort-req 2, in-progress 0.
// R18: control addressing: dest_pointer_mode 7:6, dest_reload_stop 5, smr 4:3, source_pointer_mode 2:1, source_reload_stop 0.
// R19: counters load at start, decrement per transaction, reload at one.
// R20: transaction reads source into buffer then writes it, each after grant.
// R21: in-progress set when byte fetched, cleared when byte written.
// R22: reload-stop also clears start-request enable together with go.
// R23: flags sticky until software clears; request output gated by enables.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module dsc_dma_channel #(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned TRIG_W = 6,
  parameter int unsigned ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic [(2**TRIG_W)-1:0] startTrig,
  input wire logic [(2**TRIG_W)-1:0] abortTrig,
  output logic readReq,
  input wire logic readGrant,
  input wire logic [7:0] readData,
  output logic writeReq,
  input wire logic writeGrant,
  output logic [7:0] writeData,
  output logic sourceReload,
  output logic destReload,
  output logic [1:0] destPointerMode,
  output logic [1:0] sourcePointerMode,
  output logic [1:0] sourceMemoryRegion,
  output logic [3:0] irqReq
);

  typedef struct packed {
    logic enable;
    logic startReqEn;
    logic go;
    logic abortReqEn;
    logic [7:0] ctrlAddr;
    logic [CNT_W-1:0] srcSize;
    logic [CNT_W-1:0] dstSize;
    logic [7:0] startSel;
    logic [7:0] abortSel;
    logic [3:0] flags;
    logic [3:0] intEn;
    dsc_pkg::dsc_xfer_type xfer;
    logic [7:0] buffer;
    logic loaded;
    logic trigPending;
    logic awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dsc_chan_state_type;

  dsc_chan_state_type q;
  dsc_chan_state_type d;

  dsc_count_if #(.CNT_W(CNT_W)) srcIf ();
  dsc_count_if #(.CNT_W(CNT_W)) dstIf ();

  dsc_count_unit #(.CNT_W(CNT_W)) srcCounter (
    .clock(clock),
    .rst(rst),
    .cnt(srcIf.counter)
  );

  dsc_count_unit #(.CNT_W(CNT_W)) dstCounter (
    .clock(clock),
    .rst(rst),
    .cnt(dstIf.counter)
  );

  // merge a write into a 32-bit view of a register, honouring byte strobes
  function automatic logic [31:0] mergeBytes(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // a select value beyond the trigger vector picks no trigger
  function automatic logic pickTrig(
    input logic [(2**TRIG_W)-1:0] trigs,
    input logic [7:0] sel
  );
    logic hit;
    hit = 1'b0;
    if ((32'(sel) >> TRIG_W) == 32'd0) begin
      hit = trigs[sel[TRIG_W-1:0]];
    end
    return hit;
  endfunction

  logic awFire;
  logic wFire;
  logic arFire;
  logic haveAw;
  logic haveW;
  logic doWrite;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic [31:0] rdWord;
  logic rdErr;
  logic [7:0] ctrlMainView;
  logic active;
  logic loadNow;
  logic fetchDone;
  logic storeDone;
  logic stopOnReload;
  logic startHit;
  logic abortHit;

  always_comb begin
    ctrlMainView = 8'h00; // R17
    ctrlMainView[dsc_pkg::CM_ENABLE] = q.enable;
    ctrlMainView[dsc_pkg::CM_START_REQ] = q.startReqEn;
    ctrlMainView[dsc_pkg::CM_GO] = q.go;
    ctrlMainView[dsc_pkg::CM_ABORT_REQ] = q.abortReqEn;
    ctrlMainView[dsc_pkg::CM_XIP] = (q.xfer == dsc_pkg::XS_STORE); // R21
  end

  // register read decode
  always_comb begin
    rdWord = 32'h0000_0000;
    rdErr = 1'b0;
    unique case (8'(s_axi_araddr))
      dsc_pkg::OFF_CTRL_MAIN: rdWord = 32'(ctrlMainView);
      dsc_pkg::OFF_CTRL_ADDR: rdWord = 32'(q.ctrlAddr);
      dsc_pkg::OFF_SRC_SIZE: rdWord = 32'(q.srcSize);
      dsc_pkg::OFF_DST_SIZE: rdWord = 32'(q.dstSize);
      dsc_pkg::OFF_START_SEL: rdWord = 32'(q.startSel);
      dsc_pkg::OFF_ABORT_SEL: rdWord = 32'(q.abortSel);
      dsc_pkg::OFF_FLAGS: rdWord = 32'(q.flags);
      dsc_pkg::OFF_INT_EN: rdWord = 32'(q.intEn);
      dsc_pkg::OFF_SRC_COUNT: rdWord = 32'(srcIf.count);
      dsc_pkg::OFF_DST_COUNT: rdWord = 32'(dstIf.count);
      dsc_pkg::OFF_BUFFER: rdWord = 32'(q.buffer);
      default: rdErr = 1'b1;
    endcase
  end

  always_comb begin
    d = q;
    s_axi_awready = !q.awHeld && !q.bvalid;
    s_axi_wready = !q.wHeld && !q.bvalid;
    s_axi_arready = !q.rvalid;
    awFire = s_axi_awvalid && s_axi_awready;
    wFire = s_axi_wvalid && s_axi_wready;
    arFire = s_axi_arvalid && s_axi_arready;
    haveAw = q.awHeld || awFire;
    haveW = q.wHeld || wFire;
    wrAddr = q.awHeld ? q.awAddr : s_axi_awaddr;
    wrData = q.wHeld ? q.wData : s_axi_wdata;
    wrStrb = q.wHeld ? q.wStrb : s_axi_wstrb;
    doWrite = haveAw && haveW && !q.bvalid;

    // hard stop: go, both request enables and engine state return to default; setup registers, flags, buffer and counts stay
    if (!q.enable) begin
      d.go = 1'b0; // R11
      d.startReqEn = 1'b0; // R11
      d.abortReqEn = 1'b0; // R11
      d.xfer = dsc_pkg::XS_FETCH; // R11
      d.loaded = 1'b0; // R11
      d.trigPending = 1'b0; // R11
    end

    // write channel: address and data may arrive in either order
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (doWrite) begin
      d.awHeld = 1'b0;
      d.wHeld = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = dsc_pkg::RESP_OKAY;
      unique case (8'(wrAddr))
        dsc_pkg::OFF_CTRL_MAIN: begin
          if (wrStrb[0]) begin
            d.enable = wrData[dsc_pkg::CM_ENABLE]; // R17
            d.startReqEn = wrData[dsc_pkg::CM_START_REQ]; // R16
            d.go = wrData[dsc_pkg::CM_GO]; // R5
            d.abortReqEn = wrData[dsc_pkg::CM_ABORT_REQ]; // R16
          end
        end
        dsc_pkg::OFF_CTRL_ADDR: begin
          d.ctrlAddr = 8'(mergeBytes(32'(q.ctrlAddr), wrData, wrStrb)); // R18
        end
        dsc_pkg::OFF_SRC_SIZE: begin
          d.srcSize = CNT_W'(mergeBytes(32'(q.srcSize), wrData, wrStrb));
        end
        dsc_pkg::OFF_DST_SIZE: begin
          d.dstSize = CNT_W'(mergeBytes(32'(q.dstSize), wrData, wrStrb));
        end
        dsc_pkg::OFF_START_SEL: begin
          d.startSel = 8'(mergeBytes(32'(q.startSel), wrData, wrStrb));
        end
        dsc_pkg::OFF_ABORT_SEL: begin
          d.abortSel = 8'(mergeBytes(32'(q.abortSel), wrData, wrStrb)); // R8
        end
        dsc_pkg::OFF_FLAGS: begin
          if (wrStrb[0]) begin
            d.flags = q.flags & ~wrData[3:0]; // R23
          end
        end
        dsc_pkg::OFF_INT_EN: begin
          d.intEn = 4'(mergeBytes(32'(q.intEn), wrData, wrStrb)); // R23
        end
        dsc_pkg::OFF_SRC_COUNT, dsc_pkg::OFF_DST_COUNT, dsc_pkg::OFF_BUFFER: begin
          d.bresp = dsc_pkg::RESP_OKAY;
        end
        default: d.bresp = dsc_pkg::RESP_SLVERR;
      endcase
    end else begin
      if (awFire) begin
        d.awHeld = 1'b1;
        d.awAddr = s_axi_awaddr;
      end
      if (wFire) begin
        d.wHeld = 1'b1;
        d.wData = s_axi_wdata;
        d.wStrb = s_axi_wstrb;
      end
    end

    // read channel
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (arFire) begin
      d.rvalid = 1'b1;
      d.rdata = rdWord;
      d.rresp = rdErr ? dsc_pkg::RESP_SLVERR : dsc_pkg::RESP_OKAY;
    end

    // transfer engine; go low pauses without touching any state
    active = q.enable && q.go && (!q.startReqEn || q.trigPending); // R5 R7
    loadNow = active && !q.loaded; // R19
    readReq = active && q.loaded && (q.xfer == dsc_pkg::XS_FETCH); // R20
    writeReq = q.enable && q.go && (q.xfer == dsc_pkg::XS_STORE); // R6 R20
    fetchDone = readReq && readGrant;
    storeDone = writeReq && writeGrant;
    if (loadNow) begin
      d.loaded = 1'b1; // R19
    end
    if (fetchDone) begin
      d.buffer = readData; // R20
      d.xfer = dsc_pkg::XS_STORE; // R21
    end
    stopOnReload = 1'b0;
    if (storeDone) begin
      d.xfer = dsc_pkg::XS_FETCH; // R21
      d.trigPending = 1'b0;
      stopOnReload = (srcIf.reload && q.ctrlAddr[dsc_pkg::CA_SOURCE_RELOAD_STOP]) // R1 R3 R4
        || (dstIf.reload && q.ctrlAddr[dsc_pkg::CA_DEST_RELOAD_STOP]); // R1 R2 R3
      if (srcIf.reload) begin
        d.flags[dsc_pkg::FL_SRC_COUNT] = 1'b1; // R12
      end
      if (dstIf.reload) begin
        d.flags[dsc_pkg::FL_DST_COUNT] = 1'b1; // R12
      end
      if (stopOnReload) begin
        d.go = 1'b0; // R1 R3 R4
        d.startReqEn = 1'b0; // R22
      end
    end

    // triggers
    abortHit = q.enable && q.abortReqEn && pickTrig(abortTrig, q.abortSel); // R8
    startHit = q.enable && q.startReqEn && !abortHit && pickTrig(startTrig, q.startSel);
    if (startHit) begin
      d.go = 1'b1; // R15
      d.trigPending = 1'b1; // R7
      if ((q.xfer == dsc_pkg::XS_STORE && !storeDone)
          || (q.trigPending && q.xfer == dsc_pkg::XS_FETCH)) begin
        d.flags[dsc_pkg::FL_OVERRUN] = 1'b1; // R14
      end
    end
    // abort touches only go, the two enables and the abort flag: counters, buffer and engine state stay
    if (abortHit) begin // R10
      d.go = 1'b0; // R9
      d.startReqEn = 1'b0; // R9
      d.abortReqEn = 1'b0; // R9
      d.flags[dsc_pkg::FL_ABORT] = 1'b1; // R13
    end

    srcIf.size = q.srcSize;
    dstIf.size = q.dstSize;
    srcIf.load = loadNow; // R19
    dstIf.load = loadNow; // R19
    srcIf.step = storeDone; // R19
    dstIf.step = storeDone; // R19
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
      q.ctrlAddr <= dsc_pkg::CTRL_ADDR_RST;
      q.startSel <= dsc_pkg::SEL_RST;
      q.abortSel <= dsc_pkg::SEL_RST;
      q.flags <= dsc_pkg::FLAGS_RST;
      q.intEn <= dsc_pkg::INT_EN_RST;
      q.xfer <= dsc_pkg::XS_FETCH;
      q.buffer <= dsc_pkg::BUFFER_RST;
      q.bresp <= dsc_pkg::RESP_OKAY;
      q.rresp <= dsc_pkg::RESP_OKAY;
    end else begin
      q <= d;
    end
  end

  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign writeData = q.buffer; // R6
  assign sourceReload = srcIf.reload;
  assign destReload = dstIf.reload;
  assign destPointerMode = q.ctrlAddr[dsc_pkg::CA_DEST_POINTER_MODE_LSB +: 2]; // R18
  assign sourcePointerMode = q.ctrlAddr[dsc_pkg::CA_SOURCE_POINTER_MODE_LSB +: 2]; // R18
  assign sourceMemoryRegion = q.ctrlAddr[dsc_pkg::CA_SMR_LSB +: 2]; // R18
  assign irqReq = q.flags & q.intEn; // R23

endmodule // dsc_dma_channel

// [rtl/dsc_pkg.sv]
// constants and types shared by the dma channel stop/completion logic
package dsc_pkg;

  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] OFF_CTRL_MAIN = 8'h00;
  localparam logic [7:0] OFF_CTRL_ADDR = 8'h04;
  localparam logic [7:0] OFF_SRC_SIZE = 8'h08;
  localparam logic [7:0] OFF_DST_SIZE = 8'h0C;
  localparam logic [7:0] OFF_START_SEL = 8'h10;
  localparam logic [7:0] OFF_ABORT_SEL = 8'h14;
  localparam logic [7:0] OFF_FLAGS = 8'h18;
  localparam logic [7:0] OFF_INT_EN = 8'h1C;
  localparam logic [7:0] OFF_SRC_COUNT = 8'h20;
  localparam logic [7:0] OFF_DST_COUNT = 8'h24;
  localparam logic [7:0] OFF_BUFFER = 8'h28;

  // channel_control_main fields
  localparam int unsigned CM_ENABLE = 7;
  localparam int unsigned CM_START_REQ = 6;
  localparam int unsigned CM_GO = 5;
  localparam int unsigned CM_ABORT_REQ = 2;
  localparam int unsigned CM_XIP = 0;

  // channel_control_addressing fields
  localparam int unsigned CA_DEST_POINTER_MODE_LSB = 6;
  localparam int unsigned CA_DEST_RELOAD_STOP = 5;
  localparam int unsigned CA_SMR_LSB = 3;
  localparam int unsigned CA_SOURCE_POINTER_MODE_LSB = 1;
  localparam int unsigned CA_SOURCE_RELOAD_STOP = 0;

  // status flag positions
  localparam int unsigned FL_SRC_COUNT = 0;
  localparam int unsigned FL_DST_COUNT = 1;
  localparam int unsigned FL_ABORT = 2;
  localparam int unsigned FL_OVERRUN = 3;
  localparam int unsigned FLAG_COUNT = 4;

  // reset values
  localparam logic [7:0] CTRL_ADDR_RST = 8'h00;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [3:0] INT_EN_RST = 4'h0;
  localparam logic [7:0] BUFFER_RST = 8'h00;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // byte-holding buffer empty (fetch next) or full (store pending)
  typedef enum logic {
    XS_FETCH,
    XS_STORE
  } dsc_xfer_type;

endpackage

// [rtl/dsc_count_if.sv]
// connection between the channel and one message counter
`timescale 1ns/1ps
interface dsc_count_if #(
  parameter int unsigned CNT_W = 16
);
  logic [CNT_W-1:0] size;
  logic [CNT_W-1:0] count;
  logic load;
  logic step;
  logic reload;

  modport owner (output size, output load, output step, input count, input reload);
  modport counter (input size, input load, input step, output count, output reload);
endinterface

// [rtl/dsc_count_unit.sv]
// message counter: loads from size, counts down per transaction, reloads at one
`timescale 1ns/1ps
module dsc_count_unit #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic clock,
  input wire logic rst,
  dsc_count_if.counter cnt
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
  } dsc_count_state_type;

  dsc_count_state_type q;
  dsc_count_state_type d;

  always_comb begin
    d = q;
    // a count of zero (size never written) is treated like one
    cnt.reload = cnt.step && (q.count <= CNT_W'(1)); // R19
    if (cnt.load) begin
      d.count = cnt.size; // R19
    end else if (cnt.step) begin
      if (cnt.reload) begin
        d.count = cnt.size; // R19
      end else begin
        d.count = q.count - CNT_W'(1); // R19
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cnt.count = q.count;

endmodule // dsc_count_unit

// [verif/dsc_dma_channel_properties.sv]
// port-level assertions for the dma channel, bound into the channel
`timescale 1ns/1ps
module dsc_dma_channel_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic readReq,
  input wire logic readGrant,
  input wire logic [7:0] readData,
  input wire logic writeReq,
  input wire logic writeGrant,
  input wire logic [7:0] writeData,
  input wire logic sourceReload,
  input wire logic destReload,
  input wire logic [3:0] irqReq,
  input wire logic s_axi_bvalid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  property p_oneStep;
    !(readReq && writeReq);
  endproperty
  a_oneStep: assert property (p_oneStep)
    else $error("read and write together");
  property p_bufLoad;
    readReq && readGrant |=> writeData == $past(readData);
  endproperty
  a_bufLoad: assert property (p_bufLoad)
    else $error("fetched byte not buffered");
  property p_fullNoRead;
    readReq && readGrant |=> !readReq;
  endproperty
  a_fullNoRead: assert property (p_fullNoRead)
    else $error("read while byte held");
  property p_holdByte;
    writeReq && !writeGrant |=> $stable(writeData);
  endproperty
  a_holdByte: assert property (p_holdByte)
    else $error("held byte changed");
  property p_reload;
    sourceReload || destReload |-> writeReq && writeGrant;
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload off a write");
  property p_srcFlag;
    $rose(irqReq[0]) |-> $past(sourceReload) || $rose(s_axi_bvalid);
  endproperty
  a_srcFlag: assert property (p_srcFlag)
    else $error("source flag without reload");
  property p_dstFlag;
    $rose(irqReq[1]) |-> $past(destReload) || $rose(s_axi_bvalid);
  endproperty
  a_dstFlag: assert property (p_dstFlag)
    else $error("dest flag without reload");
  property p_sticky;
    |($past(irqReq) & ~irqReq) |-> $rose(s_axi_bvalid);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag fell without write");
endmodule // dsc_dma_channel_properties
bind dsc_dma_channel dsc_dma_channel_properties u_props (.clock, .rst, .readReq, .readGrant,
  .readData, .writeReq, .writeGrant, .writeData, .sourceReload, .destReload, .irqReq,
  .s_axi_bvalid);

// [verif/dsc_mem_model.sv]
// arbiter and memory stand-in that grants the channel's bus requests
`timescale 1ns/1ps
module dsc_mem_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] delay,
  input wire logic readReq,
  input wire logic writeReq,
  output logic readGrant,
  output logic writeGrant,
  output logic [7:0] readData
);
  logic [1:0] waitQ;
  logic [7:0] srcQ;
  // off-grant the data lines show the inverse of the byte
  assign readData = readGrant ? srcQ : ~srcQ;
  always_ff @(posedge clock) begin
    if (rst) begin
      waitQ <= 2'h0;
      srcQ <= 8'h5A;
      readGrant <= 1'b0;
      writeGrant <= 1'b0;
    end else if (readGrant || writeGrant || !(readReq || writeReq)) begin
      waitQ <= 2'h0;
      readGrant <= 1'b0;
      writeGrant <= 1'b0;
      if (readGrant && readReq) srcQ <= srcQ + 8'h01;
    end else if (waitQ >= delay) begin
      readGrant <= readReq;
      writeGrant <= writeReq;
    end else begin
      waitQ <= waitQ + 2'h1;
    end
  end
endmodule // dsc_mem_model

// [verif/dsc_dma_channel_tb.sv]
// self-checking bench for the dma channel stop and completion logic
`timescale 1ns/1ps
module dsc_dma_channel_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic awV = 1'b0, wV = 1'b0, arV = 1'b0;
  logic [7:0] awA = 8'h00, arA = 8'h00;
  logic [31:0] wD = 32'h0, lfsr = 32'h7334, v, c1;
  logic [63:0] sT = 64'h0, aT = 64'h0;
  logic [1:0] dly = 2'h0, rs, rRs, dpm, spm, source_memory_region, bRs, ws;
  logic awRdy, wRdy, bV, arRdy, rV, rqR, gR, rqW, gW;
  logic [31:0] rD;
  logic [7:0] rDat, wDat;
  logic [3:0] irq;
  logic [7:0] q[$];
  int mismatches = 0, n_checks = 0, nW = 0, c, n0, n1;
  int expN[4] = '{0, 1, 2, 1};
  logic [3:0] expIrq[4] = '{4'h0, 4'h2, 4'h3, 4'h2};
  dsc_dma_channel DUT (.clock(clock), .rst(rst), .s_axi_awvalid(awV), .s_axi_awready(awRdy),
    .s_axi_awaddr(awA), .s_axi_awprot(3'h0), .s_axi_wvalid(wV), .s_axi_wready(wRdy),
    .s_axi_wdata(wD), .s_axi_wstrb(4'hF), .s_axi_bvalid(bV), .s_axi_bready(1'b1),
    .s_axi_bresp(bRs), .s_axi_arvalid(arV), .s_axi_arready(arRdy), .s_axi_araddr(arA),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rV), .s_axi_rready(1'b1), .s_axi_rdata(rD),
    .s_axi_rresp(rRs), .startTrig(sT), .abortTrig(aT), .readReq(rqR), .readGrant(gR),
    .readData(rDat), .writeReq(rqW), .writeGrant(gW), .writeData(wDat), .sourceReload(),
    .destReload(), .destPointerMode(dpm), .sourcePointerMode(spm),
    .sourceMemoryRegion(source_memory_region), .irqReq(irq));
  dsc_mem_model u_mem (.clock(clock), .rst(rst), .delay(dly), .readReq(rqR),
    .writeReq(rqW), .readGrant(gR), .writeGrant(gW), .readData(rDat));
  initial begin
    forever #2 clock = ~clock;
  end
  function automatic logic [31:0] nextLfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic fail();
    mismatches++;
    $display("[ERR] %0t wait ran out", $time);
    summarize();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // model of the byte path: every write carries the oldest fetched byte
  always @(posedge clock) begin
    lfsr <= nextLfsr(lfsr);
    dly <= lfsr[1:0];
    if (rqR === 1'b1 && gR === 1'b1) q.push_back(rDat);
    if (rqW === 1'b1 && gW === 1'b1) begin
      nW++;
      chk({24'h0, wDat}, {24'h0, q.pop_front()});
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int i;
    awA <= a;
    wD <= d;
    awV <= 1'b1;
    wV <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (awRdy === 1'b1) awV <= 1'b0;
      if (wRdy === 1'b1) wV <= 1'b0;
      if (bV === 1'b1) break;
    end
    if (i == 50) fail();
    ws = bRs;
  endtask
  task automatic axr(input logic [7:0] a);
    int i;
    arA <= a;
    arV <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (arRdy === 1'b1) arV <= 1'b0;
      if (rV === 1'b1) break;
    end
    if (i == 50) fail();
    v = rD;
    rs = rRs;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    axr(a);
    chk(v & m, e);
    chk({30'h0, rs}, {30'h0, dsc_pkg::RESP_OKAY});
  endtask
  task automatic ctl(input logic [31:0] d);
    axw(dsc_pkg::OFF_CTRL_MAIN, d);
  endtask
  task automatic wgo();
    int k;
    for (k = 0; k < 40; k++) begin
      axr(dsc_pkg::OFF_CTRL_MAIN);
      if (v[5] === 1'b0) break;
    end
    if (k == 40) fail();
    tick(2);
  endtask
  task automatic fire(input int t, input bit ab, input int n);
    if (ab) aT[t] <= 1'b1;
    else sT[t] <= 1'b1;
    tick(n);
    aT <= 64'h0;
    sT <= 64'h0;
    tick(14);
  endtask
  initial begin
    tick(20);
    rst <= 1'b0;
    tick(1);
    rdc(dsc_pkg::OFF_CTRL_MAIN, 32'h0, 32'hFF);
    rdc(dsc_pkg::OFF_FLAGS, 32'h0, 32'hF);
    axr(8'h2C);
    chk({30'h0, rs}, {30'h0, dsc_pkg::RESP_SLVERR});
    axw(8'h2C, 32'hFF);
    chk({30'h0, ws}, {30'h0, dsc_pkg::RESP_SLVERR});
    axw(dsc_pkg::OFF_CTRL_ADDR, 32'h7A);
    chk({30'h0, ws}, {30'h0, dsc_pkg::RESP_OKAY});
    rdc(dsc_pkg::OFF_CTRL_ADDR, 32'h7A, 32'hFF);
    chk({26'h0, dpm, source_memory_region, spm}, 32'h1D);
    axw(dsc_pkg::OFF_INT_EN, 32'hF);
    axw(dsc_pkg::OFF_SRC_SIZE, 32'h2);
    axw(dsc_pkg::OFF_DST_SIZE, 32'h1);
    $display("test registers done");
    for (c = 0; c < 4; c++) begin
      axw(dsc_pkg::OFF_CTRL_ADDR, {26'h0, c[0], 4'h0, c[1]});
      axw(dsc_pkg::OFF_FLAGS, 32'hF);
      // hard stop first so both counters start each case from their sizes
      ctl(32'h00);
      n0 = nW;
      ctl(32'hA0);
      if (c == 0) begin
        tick(40);
        rdc(dsc_pkg::OFF_CTRL_MAIN, 32'hA0, 32'hFE);
        ctl(32'h80);
        tick(4);
        n1 = nW;
        axr(dsc_pkg::OFF_SRC_COUNT);
        c1 = v;
        tick(20);
        chk(nW, n1);
        rdc(dsc_pkg::OFF_SRC_COUNT, c1, 32'hFFFFFFFF);
        ctl(32'hA0);
        tick(30);
        chk({31'h0, nW > n1}, 32'h1);
        ctl(32'h80);
        tick(4);
        ctl(32'h00);
        rdc(dsc_pkg::OFF_CTRL_MAIN, 32'h0, 32'hFF);
        q.delete();
      end else begin
        wgo();
        chk(nW - n0, expN[c]);
        rdc(dsc_pkg::OFF_CTRL_MAIN, 32'h80, 32'hFF);
        chk({28'h0, irq}, {28'h0, expIrq[c]});
      end
    end
    $display("test completion done");
    axw(dsc_pkg::OFF_CTRL_ADDR, 32'h1);
    axw(dsc_pkg::OFF_SRC_SIZE, 32'h3);
    axw(dsc_pkg::OFF_START_SEL, 32'h5);
    ctl(32'h00);
    axw(dsc_pkg::OFF_FLAGS, 32'hF);
    n0 = nW;
    ctl(32'hC0);
    fire(4, 1'b0, 1);
    chk(nW, n0);
    fire(5, 1'b0, 2);
    repeat (4) fire(5, 1'b0, 1);
    chk(nW - n0, 32'h3);
    rdc(dsc_pkg::OFF_CTRL_MAIN, 32'h80, 32'hFF);
    chk({28'h0, irq}, 32'hB);
    axw(dsc_pkg::OFF_FLAGS, 32'hF);
    chk({28'h0, irq}, 32'h0);
    $display("test hardware start done");
    axw(dsc_pkg::OFF_CTRL_ADDR, 32'h0);
    axw(dsc_pkg::OFF_ABORT_SEL, 32'h9);
    ctl(32'hA0);
    fire(9, 1'b1, 1);
    rdc(dsc_pkg::OFF_CTRL_MAIN, 32'hA0, 32'hFE);
    ctl(32'hA4);
    fire(8, 1'b1, 1);
    rdc(dsc_pkg::OFF_CTRL_MAIN, 32'hA4, 32'hFE);
    fire(9, 1'b1, 1);
    rdc(dsc_pkg::OFF_CTRL_MAIN, 32'h80, 32'hFE);
    chk({31'h0, irq[2]}, 32'h1);
    n1 = nW;
    ctl(32'hC4);
    repeat (2) fire(5, 1'b0, 1);
    chk({31'h0, nW > n1}, 32'h1);
    ctl(32'h80);
    tick(4);
    axw(dsc_pkg::OFF_INT_EN, 32'h0);
    chk({28'h0, irq}, 32'h0);
    $display("test abort done");
    summarize();
  end
endmodule // dsc_dma_channel_tb
